/* File: fte_pkg.sv */
package fte_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_CHK = 8'h18;

  // Control field positions
  localparam int CTRL_CORRECT = 0;
  localparam int CTRL_NARROW = 1;
  localparam int CTRL_PATH = 2;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_DIAG = 4;
  localparam int CTRL_LISTEN = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h04;

  // Command and status fields
  localparam int CMD_GO = 0;
  localparam int CMD_READ = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FIX = 2;
  localparam int STAT_UNFIX = 3;

  // Device timing
  localparam int DEV_DELAY_NS = 32;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DEV_DELAY_CYC = (DEV_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES = 2;
  localparam int SETTLE_CYC = DEV_DELAY_CYC + SYNC_STAGES;

  // Word layout
  localparam int DATA_W = 16;
  localparam int CHK_W = 8;
  localparam int NARROW_CHK_W = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PREP = 3'h1,
    ST_DRIVE = 3'h3,
    ST_SETTLE = 3'h2,
    ST_CAPT = 3'h6,
    ST_REL = 3'h7
  } fte_state_t;

endpackage

/* File: fte_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fte_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset
  input wire logic [W-1:0] async_i, // Pin level
  output logic [W-1:0] sync_o // Synchronised level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

/* File: fte_store.sv */
`timescale 1ns/1ps
`default_nettype none
module fte_store #(
  parameter int AW = 10,
  parameter int DW = 24
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [DW-1:0] wdata, // Write word
  output logic [DW-1:0] rdata // Registered read word
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

/* File: fte_host.sv */
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fte_host
  import fte_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // APB reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic correct_mode, // Correct mode pin
  output logic narrow_code_sel, // Six check bit select
  output logic path_sel, // Memory or buffer path
  output logic master_port_sel, // High: port b is master
  output logic diag_readout_sel_n, // Syndrome readout, active low
  output logic port_a_dir, // Port a read high
  output logic port_a_out_en_n, // Port a output enable
  output logic port_a_storage_sel_n, // Port a memory select
  output logic port_b_dir, // Port b read high
  output logic port_b_out_en_n, // Port b output enable
  output logic port_b_storage_sel_n, // Port b memory select
  input wire logic [15:0] port_a_word_i, // Port a bus level
  output logic [15:0] port_a_word_o, // Port a drive value
  output logic port_a_word_oe, // Port a drive enable
  input wire logic [15:0] port_b_word_i, // Port b bus level
  output logic [15:0] port_b_word_o, // Port b drive value
  output logic port_b_word_oe, // Port b drive enable
  input wire logic [15:0] stored_word_lines_i, // Memory data level
  output logic [15:0] stored_word_lines_o, // Memory data drive
  output logic stored_word_lines_oe, // Memory data enable
  input wire logic [7:0] stored_check_lines_i, // Check level
  output logic [7:0] stored_check_lines_o, // Check drive
  output logic [7:0] stored_check_lines_oe, // Per-bit check enable
  input wire logic fixable_fault_flag_n, // Correctable flag
  input wire logic unfixable_fault_flag_n // Uncorrectable flag
);

  if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_aw
    $error("ADDR_W out of range");
  end
  if (SETTLE_CYC > 15) begin : g_chk_cnt
    $error("Settle count too wide");
  end

  fte_state_t state_q, state_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0] wdata_q;
  logic op_read_q, done_q, fix_q, unfix_q;
  logic [31:0] rdata_q, prdata_q;
  logic [7:0] chk_q;
  logic [3:0] cnt_q;
  logic pready_q, pslverr_q, diag_n_q;
  logic a_dir_q, a_oen_q, a_sel_q, b_dir_q, b_oen_q, b_sel_q, a_woe_q, b_woe_q;
  logic m_word_oe_q;
  logic [7:0] m_chk_oe_q;
  logic [15:0] m_word_q;
  logic [7:0] m_chk_q;

  // Synchronised pins
  logic [1:0] flags_s;
  logic [15:0] a_word_s, b_word_s;
  logic [23:0] stored_s;
  logic [23:0] store_rd;

  fte_sync #(.W(2), .RST_VAL(2'h3)) u_sync_flag (
    .pclk(pclk), .presetn(presetn),
    .async_i({unfixable_fault_flag_n, fixable_fault_flag_n}), .sync_o(flags_s)
  );
  fte_sync #(.W(16), .RST_VAL(16'h0000)) u_sync_a (
    .pclk(pclk), .presetn(presetn), .async_i(port_a_word_i), .sync_o(a_word_s)
  );
  fte_sync #(.W(16), .RST_VAL(16'h0000)) u_sync_b (
    .pclk(pclk), .presetn(presetn), .async_i(port_b_word_i), .sync_o(b_word_s)
  );
  fte_sync #(.W(24), .RST_VAL(24'h000000)) u_sync_m (
    .pclk(pclk), .presetn(presetn),
    .async_i({stored_check_lines_i, stored_word_lines_i}), .sync_o(stored_s)
  );

  // APB decode
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready_q;
  wire wr = commit & pwrite;
  wire idle = (state_q == ST_IDLE);
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_addr = (paddr == OFS_ADDR);
  wire hit_wdata = (paddr == OFS_WDATA);
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_stat = (paddr == OFS_STAT);
  wire hit_rdata = (paddr == OFS_RDATA);
  wire hit_chk = (paddr == OFS_CHK);
  wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_cmd | hit_stat | hit_rdata | hit_chk;
  wire go = wr & hit_cmd & pwdata[CMD_GO] & idle;
  wire stat_clr = wr & hit_stat;
  wire [31:0] rd_mux =
    hit_ctrl ? {26'h0000000, ctrl_q} :
    hit_addr ? 32'(addr_q) :
    hit_wdata ? {16'h0000, wdata_q} :
    hit_cmd ? {30'h00000000, op_read_q, 1'b0} :
    hit_stat ? {28'h0000000, unfix_q, fix_q, done_q, ~idle} :
    hit_rdata ? rdata_q :
    hit_chk ? {24'h000000, chk_q} : 32'h00000000;

  // Sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          state_d = ST_PREP;
        end
      end
      ST_PREP: state_d = ST_DRIVE;
      ST_DRIVE: state_d = ST_SETTLE;
      ST_SETTLE: begin
        if (cnt_q == 4'h1) begin
          state_d = ST_CAPT;
        end
      end
      ST_CAPT: state_d = ST_REL;
      ST_REL: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  wire active_d = (state_d == ST_DRIVE) | (state_d == ST_SETTLE) | (state_d == ST_CAPT);
  wire mem_path = ctrl_q[CTRL_PATH];
  wire master_b = ctrl_q[CTRL_MASTER];
  wire narrow = ctrl_q[CTRL_NARROW];
  wire m_dir_d = op_read_q | ~active_d;
  wire m_sel_n_d = ~(active_d & mem_path);
  wire m_oen_d = ~(active_d & op_read_q);
  wire m_woe_d = active_d & ~op_read_q;
  wire l_oen_d = ~(active_d & ctrl_q[CTRL_LISTEN]);
  // Narrow store keeps check bits 0 to 5 only
  wire [7:0] chk_keep = narrow ? 8'h3f : 8'hff;
  wire mem_drive_d = active_d & op_read_q & mem_path;
  wire mem_we = (state_q == ST_CAPT) & ~op_read_q & mem_path;
  wire [23:0] mem_wdata = {stored_s[23:16] & chk_keep, stored_s[15:0]};
  wire [15:0] m_word_s = master_b ? b_word_s : a_word_s;
  wire [15:0] l_word_s = master_b ? a_word_s : b_word_s;
  wire rd_capt = (state_q == ST_CAPT) & op_read_q;

  fte_store #(.AW(ADDR_W), .DW(24)) u_store (
    .pclk(pclk), .presetn(presetn), .we(mem_we),
    .addr(addr_q), .wdata(mem_wdata), .rdata(store_rd)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Settings locked while an access runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      diag_n_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= 16'h0000;
      op_read_q <= 1'b0;
    end else begin
      if (wr & hit_ctrl & idle) ctrl_q <= pwdata[CTRL_W-1:0];
      if (wr & hit_ctrl & idle) diag_n_q <= ~pwdata[CTRL_DIAG];
      if (wr & hit_addr & idle) addr_q <= pwdata[ADDR_W-1:0];
      if (wr & hit_wdata & idle) wdata_q <= pwdata[15:0];
      if (go) op_read_q <= pwdata[CMD_READ];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == ST_DRIVE) ? 4'(SETTLE_CYC) : cnt_q - 4'h1;
    end
  end

  // Sticky results, a set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fix_q <= 1'b0;
      unfix_q <= 1'b0;
      rdata_q <= 32'h00000000;
      chk_q <= 8'h00;
    end else begin
      done_q <= (done_q & ~(stat_clr & pwdata[STAT_DONE])) | (state_q == ST_REL);
      fix_q <= (fix_q & ~(stat_clr & pwdata[STAT_FIX])) | (rd_capt & ~flags_s[0]);
      unfix_q <= (unfix_q & ~(stat_clr & pwdata[STAT_UNFIX])) | (rd_capt & ~flags_s[1]);
      if (state_q == ST_CAPT) begin
        // Listener word kept in upper half
        rdata_q <= {l_word_s, m_word_s};
        chk_q <= stored_s[23:16] & chk_keep;
      end
    end
  end

  // Pin registers follow the master choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dir_q <= 1'b1;
      a_oen_q <= 1'b1;
      a_sel_q <= 1'b1;
      a_woe_q <= 1'b0;
      b_dir_q <= 1'b1;
      b_oen_q <= 1'b1;
      b_sel_q <= 1'b1;
      b_woe_q <= 1'b0;
      m_word_oe_q <= 1'b0;
      m_chk_oe_q <= 8'h00;
      m_word_q <= 16'h0000;
      m_chk_q <= 8'h00;
    end else begin
      a_dir_q <= master_b ? 1'b1 : m_dir_d;
      a_oen_q <= master_b ? l_oen_d : m_oen_d;
      a_sel_q <= master_b ? 1'b1 : m_sel_n_d;
      a_woe_q <= master_b ? 1'b0 : m_woe_d;
      b_dir_q <= master_b ? m_dir_d : 1'b1;
      b_oen_q <= master_b ? m_oen_d : l_oen_d;
      b_sel_q <= master_b ? m_sel_n_d : 1'b1;
      b_woe_q <= master_b ? m_woe_d : 1'b0;
      m_word_oe_q <= mem_drive_d;
      m_chk_oe_q <= mem_drive_d ? chk_keep : 8'h00;
      m_word_q <= store_rd[15:0];
      m_chk_q <= store_rd[23:16];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign correct_mode = ctrl_q[CTRL_CORRECT];
  assign narrow_code_sel = ctrl_q[CTRL_NARROW];
  assign path_sel = ctrl_q[CTRL_PATH];
  assign master_port_sel = ctrl_q[CTRL_MASTER];
  assign diag_readout_sel_n = diag_n_q;
  assign port_a_dir = a_dir_q;
  assign port_a_out_en_n = a_oen_q;
  assign port_a_storage_sel_n = a_sel_q;
  assign port_b_dir = b_dir_q;
  assign port_b_out_en_n = b_oen_q;
  assign port_b_storage_sel_n = b_sel_q;
  assign port_a_word_o = wdata_q;
  assign port_a_word_oe = a_woe_q;
  assign port_b_word_o = wdata_q;
  assign port_b_word_oe = b_woe_q;
  assign stored_word_lines_o = m_word_q;
  assign stored_word_lines_oe = m_word_oe_q;
  assign stored_check_lines_o = m_chk_q;
  assign stored_check_lines_oe = m_chk_oe_q;

  slave_sel_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (master_port_sel ? port_a_storage_sel_n : port_b_storage_sel_n) && (master_port_sel ? !a_woe_q : !b_woe_q))
    else $error("Non-master port selects memory or drives");

  master_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_SETTLE && $past(state_q) == ST_SETTLE) |->
      $stable(a_dir_q) && $stable(b_dir_q) && $stable(a_sel_q) && $stable(b_sel_q))
    else $error("Master controls moved during settle");

  port_drive_excl_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(a_woe_q && !a_oen_q) && !(b_woe_q && !b_oen_q))
    else $error("Port driven from both ends");

  settle_span_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_DRIVE) |-> ##11 (state_q == ST_CAPT) ##1 (state_q == ST_REL))
    else $error("Settle time wrong");

  narrow_store_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mem_we && narrow) |-> (mem_wdata[23:22] == 2'b00))
    else $error("Narrow store kept check bits 6 or 7");

  mem_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_SETTLE && op_read_q && mem_path) |->
      stored_word_lines_oe && (stored_check_lines_oe == chk_keep))
    else $error("Memory not driving on read");

  detect_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!idle && $past(state_q) != ST_IDLE) |-> $stable(correct_mode))
    else $error("Mode changed during access");

endmodule
`default_nettype wire

/* File: fte_dev.sv */
`timescale 1ns/1ps
`default_nettype none
package fte_vpkg;
  function automatic logic [7:0] gen(input logic [15:0] w);
    return {~^(w & 16'hb82e), ^(w & 16'h29b6), ^(w & 16'hf8c8), ^(w & 16'h8fa4),
      ~^(w & 16'h641f), ~^(w & 16'h922f), ^(w & 16'h4f52), ^(w & 16'h31f1)};
  endfunction
endpackage
module fte_dev
  import fte_vpkg::*;
(
  input wire logic correct_mode, // Correct mode
  input wire logic narrow_code_sel, // Six check bits
  input wire logic path_sel, // Memory path
  input wire logic master_port_sel, // Port b master
  input wire logic diag_readout_sel_n, // Diag readout
  input wire logic [1:0] dir, // Dirs b,a
  input wire logic [1:0] oe_n, // Out enables b,a
  input wire logic [1:0] sel_n, // Memory selects b,a
  input wire logic [15:0] wa, // Port a level
  input wire logic [15:0] wb, // Port b level
  input wire logic [15:0] sw, // Memory data level
  input wire logic [7:0] sc, // Check level
  output logic [15:0] da, // Port a drive
  output logic [15:0] db, // Port b drive
  output logic [1:0] den, // Port drive enables
  output logic [15:0] swo, // Memory data drive
  output logic [7:0] sco, // Check drive
  output logic mden, // Memory drive enable
  output logic fix_n, // Correctable flag
  output logic unfix_n // Uncorrectable flag
);
  logic m, rd, hit, one;
  logic [15:0] mw, dat, src, pw, lv;
  logic [15:0] buf_q = 16'h0000;
  logic [7:0] syn, msk;
  assign m = master_port_sel;
  assign mw = m ? wb : wa;
  assign msk = narrow_code_sel ? 8'h3f : 8'hff;
  assign syn = (gen(sw) ^ sc) & msk;
  assign rd = dir[m] & ~sel_n[m] & path_sel;
  always_comb begin
    dat = sw;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (syn == ((gen(16'h0001 << i) ^ gen(16'h0000)) & msk)) begin
        hit = 1'b1;
        if (correct_mode) dat[i] = ~sw[i];
      end
    end
  end
  assign one = (syn != 8'h00) & ((syn & (syn - 8'h01)) == 8'h00);
  assign fix_n = ~(rd & (hit | one));
  assign unfix_n = ~(rd & (syn != 8'h00) & ~hit & ~one);
  always @(negedge dir[m]) begin
    #2;
    if (!path_sel) buf_q = mw;
  end
  assign src = path_sel ? dat : buf_q;
  assign pw = diag_readout_sel_n ? src : {syn, sc};
  assign lv = dir[m] ? src : mw;
  assign da = m ? lv : pw;
  assign db = m ? pw : lv;
  assign den = {~oe_n[1] & (dir[1] | ~m), ~oe_n[0] & (dir[0] | m)};
  assign mden = ~dir[m] & ~sel_n[m] & path_sel;
  assign swo = mw;
  assign sco = gen(mw);
endmodule
`default_nettype wire

/* File: dual_port_flow_through_edac_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_port_flow_through_edac_tb
  import fte_pkg::*, fte_vpkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq, g_rd, g_ck, g_st;
  logic correct_mode, narrow_code_sel, path_sel, master_port_sel, diag_readout_sel_n;
  logic port_a_dir, port_a_out_en_n, port_a_storage_sel_n, port_b_dir, port_b_out_en_n, port_b_storage_sel_n;
  logic port_a_word_oe, port_b_word_oe, stored_word_lines_oe, mden, fix_n, unfix_n;
  logic [15:0] port_a_word_o, port_b_word_o, stored_word_lines_o, pa, pb, swl, da, db, swo, inj_d;
  logic [7:0] stored_check_lines_o, stored_check_lines_oe, scl, sco, inj_c;
  logic [1:0] den;
  int num_errors = 0;
  int checks_done = 0;
  int nsel = 0;
  int k0;
  logic [15:0] tw [4] = '{16'h0000, 16'hffff, 16'h8001, 16'ha5c3};
  always #2 pclk = ~pclk;
  fte_host i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .correct_mode, .narrow_code_sel, .path_sel, .master_port_sel, .diag_readout_sel_n, .port_a_dir,
    .port_a_out_en_n, .port_a_storage_sel_n, .port_b_dir, .port_b_out_en_n, .port_b_storage_sel_n,
    .port_a_word_i(pa), .port_a_word_o, .port_a_word_oe, .port_b_word_i(pb), .port_b_word_o, .port_b_word_oe,
    .stored_word_lines_i(swl), .stored_word_lines_o, .stored_word_lines_oe, .stored_check_lines_i(scl),
    .stored_check_lines_o, .stored_check_lines_oe, .fixable_fault_flag_n(fix_n), .unfixable_fault_flag_n(unfix_n));
  fte_dev i_dev (.correct_mode, .narrow_code_sel, .path_sel, .master_port_sel, .diag_readout_sel_n,
    .dir({port_b_dir, port_a_dir}), .oe_n({port_b_out_en_n, port_a_out_en_n}),
    .sel_n({port_b_storage_sel_n, port_a_storage_sel_n}), .wa(pa), .wb(pb), .sw(swl), .sc(scl),
    .da, .db, .den, .swo, .sco, .mden, .fix_n, .unfix_n);
  // Pull-ups hold released lines high
  assign pa = port_a_word_oe ? port_a_word_o : (den[0] ? da : 16'hffff);
  assign pb = port_b_word_oe ? port_b_word_o : (den[1] ? db : 16'hffff);
  assign swl = stored_word_lines_oe ? stored_word_lines_o ^ inj_d : (mden ? swo : 16'hffff);
  assign scl = (stored_check_lines_oe & (stored_check_lines_o ^ inj_c)) | (~stored_check_lines_oe & (mden ? sco : 8'hff));
  always @(negedge port_a_storage_sel_n or negedge port_b_storage_sel_n) nsel++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fin();
    do acc(1'b0, OFS_STAT, 32'h0); while (rq[STAT_DONE] !== 1'b1);
    acc(1'b0, OFS_RDATA, 32'h0);
    g_rd = rq;
    acc(1'b0, OFS_CHK, 32'h0);
    g_ck = rq;
    acc(1'b0, OFS_STAT, 32'h0);
    g_st = rq;
    acc(1'b1, OFS_STAT, 32'he);
  endtask
  task automatic run(input logic [5:0] c, input logic [15:0] a, input logic [15:0] d, input logic r);
    acc(1'b1, OFS_CTRL, {26'h0, c});
    acc(1'b1, OFS_ADDR, {16'h0, a});
    acc(1'b1, OFS_WDATA, {16'h0, d});
    acc(1'b1, OFS_CMD, {30'h0, r, 1'b1});
    fin();
  endtask
  // Read back word a5c3 at address 3 with faults injected on the memory side
  task automatic err(input logic [5:0] c, input logic [15:0] di, input logic [7:0] ci, input logic [15:0] e,
      input logic [3:0] s);
    inj_d <= di;
    inj_c <= ci;
    run(c, 16'h3, 16'h0, 1'b1);
    chk("rdata", {16'hffff, e}, g_rd);
    chk("check", {24'h0, gen(16'ha5c3) ^ ci}, g_ck);
    chk("stat", {28'h0, s}, g_st);
    inj_d <= 16'h0;
    inj_c <= 8'h0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    inj_d = 16'h0;
    inj_c = 8'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h4, rq);
    chk("pins", 32'hff, {24'h0, path_sel, diag_readout_sel_n, port_a_dir, port_b_dir, port_a_out_en_n,
      port_b_out_en_n, port_a_storage_sel_n, port_b_storage_sel_n});
    acc(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h0, rq);
    chk("slverr", 32'h1, {31'h0, re});
    for (int n = 1; n >= 0; n--) begin
      for (int k = 0; k < 4; k++) begin
        run(6'h05 | 6'(n << 1), 16'(k), tw[k], 1'b0);
        run(6'h05 | 6'(n << 1), 16'(k), 16'h0, 1'b1);
        chk("rdata", {16'hffff, tw[k]}, g_rd);
        chk("check", {24'h0, gen(tw[k]) & (n == 1 ? 8'h3f : 8'hff)}, g_ck);
        chk("stat", 32'h2, g_st);
      end
    end
    err(6'h05, 16'h0020, 8'h00, 16'ha5c3, 4'h6);
    err(6'h04, 16'h0020, 8'h00, 16'ha5e3, 4'h6);
    err(6'h05, 16'h0011, 8'h00, 16'ha5d2, 4'ha);
    err(6'h05, 16'h0000, 8'h04, 16'ha5c3, 4'h6);
    err(6'h15, 16'h0004, 8'h00, {8'hdc, gen(16'ha5c3)}, 4'h6);
    run(6'h2d, 16'h2, 16'h0, 1'b1);
    chk("listen", {tw[2], tw[2]}, g_rd);
    run(6'h0d, 16'h9, 16'h3c5a, 1'b0);
    run(6'h05, 16'h9, 16'h0, 1'b1);
    chk("b_to_mem", 32'hffff3c5a, g_rd);
    k0 = nsel;
    run(6'h21, 16'h0, 16'h5a3c, 1'b0);
    chk("xfer_listen", 32'h5a3c5a3c, g_rd);
    run(6'h09, 16'h0, 16'h0, 1'b1);
    chk("xfer_b", 32'hffff5a3c, g_rd);
    chk("no_mem_sel", 32'(k0), 32'(nsel));
    acc(1'b1, OFS_CTRL, 32'h5);
    acc(1'b1, OFS_CMD, 32'h3);
    acc(1'b1, OFS_CTRL, 32'h0);
    fin();
    acc(1'b0, OFS_CTRL, 32'h0);
    chk("busy_ctrl", 32'h5, rq);
    summarize();
  end
endmodule
`default_nettype wire
